// ===== include/link_cfg.svh
// Purpose: timing counts, codes and offsets of the serial memory link
// Assumes: 20 MHz system clock on both ends
// Notes: included by the package and by both ends
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH

`define CLK_NS 50
`define SCL_HALF_NS 1000
`define WAKE_US 400
`define WAKE_CW 16
`define DIV_W 8
`define ADDR_W 14

`define DEV_TYPE 4'ha
`define RSV_ID 8'hf8
`define CMD_SLEEP 8'h86
`define CMD_ID 8'hf9
`define ID_BYTES 2'h3

`define REG_CTRL 4'h0
`define REG_DATA 4'h4
`define REG_STAT 4'h8
`define CTRL_NACK 2
`define STAT_BUSY 0
`define STAT_ACK 1

`endif

// ===== include/link_pkg.sv
// Purpose: shared types of the serial memory link
// Assumes: link_cfg.svh supplies the widths
// Notes: no constants here, only types
`include "link_cfg.svh"
package link_pkg;
    typedef enum logic [2:0] {P_IDLE, P_RX, P_ACK, P_TX, P_MACK} phase_t;
    typedef enum logic [2:0] {
        S_SLV, S_AHI, S_ALO, S_WDATA, S_RSV, S_RSVW, S_RDMEM, S_RDID
    } stage_t;
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_t;

    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
    } sync_st_t;

    typedef struct packed {
        logic wp_m;
        logic wp;
        logic [2:0] asel_m;
        logic [2:0] asel;
        phase_t phase;
        stage_t stage;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic ack;
        logic ack_on;
        logic [`ADDR_W-1:0] addr;
        logic [5:0] ahi;
        logic [1:0] id_idx;
        logic rsv_ok;
        logic sleep_pend;
        logic asleep;
        logic [`WAKE_CW-1:0] wake_cnt;
    } dev_st_t;

    typedef struct packed {
        logic busy;
        op_t op;
        logic nack_rd;
        logic [4:0] hcnt;
        logic [`DIV_W-1:0] div;
        logic scl;
        logic sda;
        logic [7:0] txb;
        logic [7:0] rxb;
        logic ack_seen;
        logic rd_ok;
        logic [31:0] rdata;
    } hst_st_t;
endpackage

// ===== include/i2c_link_if.sv
// Purpose: open-drain two-wire link between bus master and memory slave
// Assumes: an enable low means that end pulls its line
// Notes: wired-and resolution happens here, never in the ends
interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

    modport master (
        output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n,
        input scl, sda
    );
    modport slave (
        output s_sda_o, s_sda_oe_n,
        input scl, sda
    );
endinterface

// ===== core/line_sync.sv
// Purpose: two-flop capture of the link lines plus edge and condition flags
// Assumes: lines are asynchronous to the local clock
// Notes: flags are one-cycle pulses, two cycles behind the pins
module line_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic rise_o,
    output logic fall_o,
    output logic start_o,
    output logic stop_o
);
    link_pkg::sync_st_t s_ff, nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.scl = {s_ff.scl[1:0], scl_i};
        nxt_s.sda = {s_ff.sda[1:0], sda_i};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // stage 0 feeds stage 1 only
    assign scl_o = s_ff.scl[1];
    assign sda_o = s_ff.sda[1];
    assign rise_o = s_ff.scl[1] & ~s_ff.scl[2];
    assign fall_o = ~s_ff.scl[1] & s_ff.scl[2];
    assign start_o = s_ff.scl[1] & s_ff.scl[2] & s_ff.sda[2] & ~s_ff.sda[1];
    assign stop_o = s_ff.scl[1] & s_ff.scl[2] & ~s_ff.sda[2] & s_ff.sda[1];
endmodule // line_sync

// ===== core/nvm_slave.sv
// Purpose: slave end of a 16K x 8 nonvolatile memory on the two-wire link
// Assumes: link lines, write-protect and select pins are asynchronous
// Notes: memory array has no reset; only the control state does
//
// Our own choices: the register addresses and register access over Avalon-MM.
`include "link_cfg.svh"
module nvm_slave #(
    parameter int WAKE_CYC = (`WAKE_US * 1000) / `CLK_NS,
    // identification field values are arbitrary
    parameter logic [11:0] ID_MAKER = 12'h5a3,
    parameter logic [3:0] ID_DENSITY = 4'h2,
    parameter logic [4:0] ID_VARIANT = 5'h06,
    parameter logic [2:0] ID_REV = 3'h2
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic WP_I,
    input wire logic [2:0] ASEL_I,
    output logic SLEEP_O,
    i2c_link_if.slave LINK
);
    localparam int DEPTH = 1 << `ADDR_W;
    localparam logic [`WAKE_CW-1:0] WAKE_LD = `WAKE_CW'(WAKE_CYC);

    link_pkg::dev_st_t s_ff, nxt_s;
    logic [7:0] mem [DEPTH];
    logic sda, rise, fall, start, stop;
    logic wr_en;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [6:0] own;
    logic [23:0] id_word;
    logic drive_low;

    assign id_word = {ID_MAKER, ID_DENSITY & 4'hf, ID_VARIANT & 5'h0e, ID_REV};

    function automatic logic [7:0] id_byte(input logic [1:0] idx,
                                           input logic [23:0] w);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            2'h0: b = w[23:16];
            2'h1: b = w[15:8];
            2'h2: b = w[7:0];
            default: b = 8'hff;
        endcase
        return b;
    endfunction

    line_sync u_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .scl_i(LINK.scl),
        .sda_i(LINK.sda),
        .scl_o(),
        .sda_o(sda),
        .rise_o(rise),
        .fall_o(fall),
        .start_o(start),
        .stop_o(stop)
    );

    assign rx_byte = {s_ff.shreg[6:0], sda};
    assign own = {`DEV_TYPE, s_ff.asel};
    assign tx_byte = (s_ff.stage == link_pkg::S_RDID) ?
                     id_byte(s_ff.id_idx, id_word) : mem[s_ff.addr];

    always_comb begin
        nxt_s = s_ff;
        wr_en = 1'b0;
        nxt_s.wp_m = WP_I;
        nxt_s.wp = s_ff.wp_m;
        nxt_s.asel_m = ASEL_I;
        nxt_s.asel = s_ff.asel_m;
        if (s_ff.wake_cnt != '0) begin
            nxt_s.wake_cnt = s_ff.wake_cnt - `WAKE_CW'(1);
        end
        if (start) begin
            nxt_s.phase = link_pkg::P_RX;
            nxt_s.stage = link_pkg::S_SLV;
            nxt_s.bitcnt = 4'h0;
            nxt_s.rsv_ok = (s_ff.stage == link_pkg::S_RSVW);
        end else if (stop) begin
            nxt_s.phase = link_pkg::P_IDLE;
            nxt_s.stage = link_pkg::S_SLV;
            nxt_s.rsv_ok = 1'b0;
            nxt_s.sleep_pend = 1'b0;
            if (s_ff.sleep_pend) begin
                nxt_s.asleep = 1'b1;
            end
        end else begin
            unique case (s_ff.phase)
                link_pkg::P_IDLE: begin
                end
                link_pkg::P_RX: begin
                    if (rise) begin
                        nxt_s.shreg = rx_byte;
                        nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                    end
                    // whole byte only at eighth bit
                    if (rise && s_ff.bitcnt == 4'h7) begin
                        nxt_s.phase = link_pkg::P_ACK;
                        nxt_s.ack_on = 1'b0;
                        nxt_s.ack = 1'b0;
                        unique case (s_ff.stage)
                            link_pkg::S_SLV: begin
                                // wake on own address, nack until ready
                                if (s_ff.asleep || s_ff.wake_cnt != '0) begin
                                    if (s_ff.asleep && rx_byte[7:1] == own) begin
                                        nxt_s.asleep = 1'b0;
                                        nxt_s.wake_cnt = WAKE_LD;
                                    end
                                end else if (s_ff.rsv_ok &&
                                             rx_byte == `CMD_SLEEP) begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.sleep_pend = 1'b1;
                                    nxt_s.stage = link_pkg::S_RSVW;
                                end else if (s_ff.rsv_ok &&
                                             rx_byte == `CMD_ID) begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.id_idx = 2'h0;
                                    nxt_s.stage = link_pkg::S_RDID;
                                end else if (rx_byte == `RSV_ID) begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.stage = link_pkg::S_RSV;
                                end else if (rx_byte[7:1] == own) begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.stage = rx_byte[0] ?
                                        link_pkg::S_RDMEM : link_pkg::S_AHI;
                                end
                            end
                            link_pkg::S_RSV: begin
                                if (rx_byte[7:1] == own) begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.stage = link_pkg::S_RSVW;
                                end
                            end
                            link_pkg::S_AHI: begin
                                nxt_s.ack = 1'b1;
                                nxt_s.ahi = rx_byte[5:0];
                                nxt_s.stage = link_pkg::S_ALO;
                            end
                            link_pkg::S_ALO: begin
                                nxt_s.ack = 1'b1;
                                nxt_s.addr = {s_ff.ahi, rx_byte};
                                nxt_s.stage = link_pkg::S_WDATA;
                            end
                            link_pkg::S_WDATA: begin
                                if (!s_ff.wp) begin
                                    wr_en = 1'b1;
                                    nxt_s.ack = 1'b1;
                                    nxt_s.addr = s_ff.addr + `ADDR_W'(1);
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                link_pkg::P_ACK: begin
                    if (fall && !s_ff.ack_on) begin
                        nxt_s.ack_on = 1'b1;
                    end else if (fall) begin
                        nxt_s.ack_on = 1'b0;
                        nxt_s.bitcnt = 4'h0;
                        if (!s_ff.ack) begin
                            nxt_s.phase = link_pkg::P_IDLE;
                        end else if (s_ff.stage == link_pkg::S_RDMEM ||
                                     s_ff.stage == link_pkg::S_RDID) begin
                            nxt_s.phase = link_pkg::P_TX;
                            nxt_s.shreg = tx_byte;
                        end else begin
                            nxt_s.phase = link_pkg::P_RX;
                        end
                    end
                end
                link_pkg::P_TX: begin
                    if (rise) begin
                        nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                    end
                    if (fall && s_ff.bitcnt == 4'h8) begin
                        nxt_s.phase = link_pkg::P_MACK;
                        nxt_s.ack = 1'b0;
                        if (s_ff.stage == link_pkg::S_RDID) begin
                            nxt_s.id_idx = s_ff.id_idx + 2'h1;
                        end else begin
                            nxt_s.addr = s_ff.addr + `ADDR_W'(1);
                        end
                    end else if (fall) begin
                        nxt_s.shreg = {s_ff.shreg[6:0], 1'b1};
                    end
                end
                link_pkg::P_MACK: begin
                    if (rise) begin
                        nxt_s.ack = ~sda;
                    end
                    // no-ack or third byte ends id read
                    if (fall) begin
                        nxt_s.bitcnt = 4'h0;
                        if (s_ff.ack && !(s_ff.stage == link_pkg::S_RDID &&
                                          s_ff.id_idx == `ID_BYTES)) begin
                            nxt_s.phase = link_pkg::P_TX;
                            nxt_s.shreg = tx_byte;
                        end else begin
                            nxt_s.phase = link_pkg::P_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_s.phase = link_pkg::P_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // array written only after eighth bit
    always_ff @(posedge MCLK_I) begin
        if (wr_en) begin
            mem[s_ff.addr] <= rx_byte;
        end
    end

    // STOP lands in P_IDLE and START in P_RX above
    // combinational so data leads the next rise by the half period less the sync delay
    assign drive_low =
        (s_ff.phase == link_pkg::P_ACK && s_ff.ack_on && s_ff.ack) ||
        (s_ff.phase == link_pkg::P_TX && !s_ff.shreg[7]);
    assign LINK.s_sda_o = 1'b0;
    assign LINK.s_sda_oe_n = ~drive_low;
    assign SLEEP_O = s_ff.asleep;
endmodule // nvm_slave

// ===== core/bus_master.sv
// Purpose: two-wire bus master driven by software over Avalon-MM
// Assumes: slave never stretches the clock
// Notes: one bus operation at a time; ctrl writes stall while busy
`include "link_cfg.svh"
module bus_master #(
    parameter int HALF_CYC = `SCL_HALF_NS / `CLK_NS
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    i2c_link_if.master LINK
);
    localparam logic [`DIV_W-1:0] HALF_LAST = `DIV_W'(HALF_CYC - 1);

    link_pkg::hst_st_t s_ff, nxt_s;
    logic sda, tick, k_ack;
    logic [3:0] k;

    line_sync u_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .scl_i(LINK.scl),
        .sda_i(LINK.sda),
        .scl_o(),
        .sda_o(sda),
        .rise_o(),
        .fall_o(),
        .start_o(),
        .stop_o()
    );

    assign tick = s_ff.busy && s_ff.div == HALF_LAST;
    assign k = s_ff.hcnt[4:1];
    assign k_ack = (k == 4'h8);

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rd_ok = 1'b0;
        if (AVS_READ_I && !s_ff.rd_ok) begin
            nxt_s.rd_ok = 1'b1;
            unique case (AVS_ADDRESS_I)
                `REG_DATA: nxt_s.rdata = {24'h000000, s_ff.rxb};
                `REG_STAT: nxt_s.rdata = {30'h00000000, s_ff.ack_seen,
                                          s_ff.busy};
                default: nxt_s.rdata = 32'h00000000;
            endcase
        end
        if (AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
            if (AVS_ADDRESS_I == `REG_DATA) begin
                nxt_s.txb = AVS_WRITEDATA_I[7:0];
            end else if (AVS_ADDRESS_I == `REG_CTRL && !s_ff.busy) begin
                nxt_s.busy = 1'b1;
                nxt_s.op = link_pkg::op_t'(AVS_WRITEDATA_I[1:0]);
                nxt_s.nack_rd = AVS_WRITEDATA_I[`CTRL_NACK];
                nxt_s.hcnt = 5'h00;
                nxt_s.div = '0;
            end
        end
        if (s_ff.busy) begin
            nxt_s.div = tick ? '0 : s_ff.div + `DIV_W'(1);
        end
        if (s_ff.busy && s_ff.div == '0) begin
            unique case (s_ff.op)
                // restart needs sda high before scl rises
                link_pkg::OP_START: begin
                    nxt_s.scl = (s_ff.hcnt == 5'h1 || s_ff.hcnt == 5'h2);
                    nxt_s.sda = (s_ff.hcnt < 5'h2);
                end
                link_pkg::OP_STOP: begin
                    nxt_s.scl = (s_ff.hcnt != 5'h0);
                    nxt_s.sda = (s_ff.hcnt == 5'h2);
                end
                default: begin
                    nxt_s.scl = s_ff.hcnt[0];
                    if (!s_ff.hcnt[0]) begin
                        // write bits, released for slave ack
                        // no-ack on the chosen read byte
                        if (s_ff.op == link_pkg::OP_WRITE) begin
                            nxt_s.sda = k_ack ? 1'b1 : s_ff.txb[3'h7 - k[2:0]];
                        end else begin
                            nxt_s.sda = k_ack ? s_ff.nack_rd : 1'b1;
                        end
                    end
                end
            endcase
        end
        if (tick) begin
            nxt_s.hcnt = s_ff.hcnt + 5'h1;
            if (s_ff.op == link_pkg::OP_WRITE || s_ff.op == link_pkg::OP_READ)
            begin
                // sample at the end of the high half
                if (s_ff.hcnt[0] && !k_ack) begin
                    nxt_s.rxb = {s_ff.rxb[6:0], sda};
                end
                // ack seen on the ninth bit
                if (s_ff.hcnt[0] && k_ack) begin
                    nxt_s.ack_seen = ~sda;
                end
                if (s_ff.hcnt == 5'h11) begin
                    nxt_s.busy = 1'b0;
                end
            end else if (s_ff.hcnt == (s_ff.op == link_pkg::OP_START ?
                                       5'h3 : 5'h2)) begin
                nxt_s.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            s_ff <= '0;
            s_ff.scl <= 1'b1;
            s_ff.sda <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign AVS_WAITREQUEST_O = (AVS_READ_I && !s_ff.rd_ok) ||
        (AVS_WRITE_I && AVS_ADDRESS_I == `REG_CTRL && s_ff.busy);
    assign AVS_READDATA_O = s_ff.rdata;
    assign LINK.m_scl_o = 1'b0;
    assign LINK.m_scl_oe_n = s_ff.scl;
    assign LINK.m_sda_o = 1'b0;
    assign LINK.m_sda_oe_n = s_ff.sda;
endmodule // bus_master

// ===== sim/link_props.sv
// Purpose: wire checks on the two-wire link
// Assumes: both ends clocked by MCLK_I
// Notes: margins sized for a 20-cycle clock half
module link_props (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic m_scl_o,
    input wire logic m_scl_oe_n,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_o,
    input wire logic s_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    a_pull_only: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
        else $error("driver pulls high");
    a_reset_free: assert property ($rose(RST_N_I) |->
        m_scl_oe_n && m_sda_oe_n && s_sda_oe_n) else $error("line held");
    a_scl_high: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high short");
    a_scl_low: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low short");
    a_drive_low: assert property ($fell(s_sda_oe_n) |-> !scl)
        else $error("slave drives in high");
    a_drop_low: assert property ($rose(s_sda_oe_n) |-> !scl)
        else $error("slave drops in high");
    a_stop_free: assert property (scl && $rose(sda) |-> s_sda_oe_n)
        else $error("stop while slave drives");
    a_start_free: assert property (scl && $fell(sda) |-> s_sda_oe_n)
        else $error("start by slave");
endmodule // link_props

// ===== sim/tb_top.sv
// Purpose: drives both link ends through the master's register port
// Assumes: wake count shortened to 700 cycles
// Notes: memory model knows only bytes written in this run
`include "link_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] SEL = 3'h5;
    logic clk = 0;
    logic rst_n = 0;
    logic wp = 0;
    logic [3:0] bbe = 4'h1;
    logic [2:0] asel = 3'h0;
    logic [3:0] ba = 0;
    logic brd = 0;
    logic bwr = 0;
    logic [31:0] bwd = 0;
    logic [31:0] bq;
    logic bwait;
    logic sleep;
    logic [31:0] q;
    logic [13:0] cur;
    logic [13:0] a;
    logic [23:0] w;
    logic [7:0] mem [int];
    int n_fail = 0;
    int comparisons = 0;
    int seed = 32'hff5e;
    int i;
    i2c_link_if i2c_link_if_inst ();
    bus_master bus_master_inst (.MCLK_I(clk), .RST_N_I(rst_n),
        .AVS_ADDRESS_I(ba), .AVS_READ_I(brd), .AVS_WRITE_I(bwr),
        .AVS_WRITEDATA_I(bwd), .AVS_BYTEENABLE_I(bbe),
        .AVS_READDATA_O(bq), .AVS_WAITREQUEST_O(bwait),
        .LINK(i2c_link_if_inst));
    // id values arbitrary
    nvm_slave #(.WAKE_CYC(700), .ID_MAKER(12'h3c5), .ID_DENSITY(4'h9),
        .ID_VARIANT(5'h1f), .ID_REV(3'h5)) nvm_slave_inst (.MCLK_I(clk),
        .RST_N_I(rst_n), .WP_I(wp), .ASEL_I(asel), .SLEEP_O(sleep),
        .LINK(i2c_link_if_inst));
    link_props link_props_inst (.MCLK_I(clk), .RST_N_I(rst_n),
        .m_scl_o(i2c_link_if_inst.m_scl_o),
        .m_scl_oe_n(i2c_link_if_inst.m_scl_oe_n),
        .m_sda_o(i2c_link_if_inst.m_sda_o),
        .m_sda_oe_n(i2c_link_if_inst.m_sda_oe_n),
        .s_sda_o(i2c_link_if_inst.s_sda_o),
        .s_sda_oe_n(i2c_link_if_inst.s_sda_oe_n),
        .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda));
    initial forever #25 clk = ~clk;
    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic give_verdict(input bit hang);
        if (hang) n_fail++;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic [3:0] ad, input logic wr,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        ba <= ad;
        bwr <= wr;
        brd <= !wr;
        bwd <= d;
        for (k = 0; k < 99; k++) begin
            @(posedge clk);
            if (bwait === 1'b0) break;
        end
        q = bq;
        bwr <= 0;
        brd <= 0;
        if (k == 99) give_verdict(1);
    endtask
    task automatic op(input link_pkg::op_t o, input logic n,
                      input logic [7:0] d);
        int k;
        if (o == link_pkg::OP_WRITE) bus(`REG_DATA, 1, {24'h0, d});
        bus(`REG_CTRL, 1, {29'h0, n, o});
        for (k = 0; k < 300; k++) begin
            bus(`REG_STAT, 0, 0);
            if (q[`STAT_BUSY] === 1'b0) break;
        end
        if (k == 300) give_verdict(1);
        if (o == link_pkg::OP_READ) bus(`REG_DATA, 0, 0);
    endtask
    task automatic wb(input logic [7:0] d, input logic e, input string s);
        op(link_pkg::OP_WRITE, 0, d);
        chk(s, {7'h0, e}, {7'h0, q[`STAT_ACK]});
    endtask
    task automatic sel(input logic [13:0] ad);
        op(link_pkg::OP_START, 0, 0);
        wb({`DEV_TYPE, SEL, 1'b0}, 1'b1, "wsel");
        wb({2'h3, ad[13:8]}, 1'b1, "hi");
        wb(ad[7:0], 1'b1, "lo");
        cur = ad;
    endtask
    task automatic wr(input logic [13:0] ad, input int n, input logic e);
        logic [7:0] d;
        sel(ad);
        repeat (n) begin
            d = 8'($random(seed));
            wb(d, e, "data");
            if (e) mem[cur] = d;
            if (e) cur++;
        end
        op(link_pkg::OP_STOP, 0, 0);
    endtask
    task automatic rd(input int n);
        int k;
        op(link_pkg::OP_START, 0, 0);
        wb({`DEV_TYPE, SEL, 1'b1}, 1'b1, "rsel");
        for (k = 1; k <= n; k++) begin
            op(link_pkg::OP_READ, k == n, 0);
            chk("rdata", mem[cur], q[7:0]);
            cur++;
        end
        op(link_pkg::OP_STOP, 0, 0);
    endtask
    task automatic rsv(input logic [7:0] c);
        op(link_pkg::OP_START, 0, 0);
        wb(`RSV_ID, 1'b1, "rsv");
        wb({`DEV_TYPE, SEL, 1'b1}, 1'b1, "rsel");
        op(link_pkg::OP_START, 0, 0);
        wb(c, 1'b1, "cmd");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        asel <= SEL;
        repeat (4) @(posedge clk);
        wr(14'h3ffe, 5, 1'b1);
        sel(14'h3ffe);
        rd(4);
        rd(1);
        // lane 0 masked: the start order must be ignored
        bbe <= 4'h0;
        bus(`REG_CTRL, 1, {29'h0, 1'b0, link_pkg::OP_START});
        bbe <= 4'h1;
        bus(`REG_STAT, 0, 0);
        chk("masked", 8'h0, {7'h0, q[`STAT_BUSY]});
        $display("test wrap done");
        for (i = 0; i < 3; i++) begin
            a = 14'($random(seed));
            wr(a, 2, 1'b1);
            sel(a);
            rd(2);
        end
        wp <= 1;
        wr(a, 2, 1'b0);
        wp <= 0;
        rd(1);
        op(link_pkg::OP_START, 0, 0);
        wb({`DEV_TYPE, ~SEL, 1'b0}, 1'b0, "other");
        op(link_pkg::OP_STOP, 0, 0);
        $display("test protect done");
        rsv(`CMD_ID);
        // reserved product bits sit at word bits 7 and 3
        w = {12'h3c5, 4'h9, 5'h1f, 3'h5} & 24'hffff77;
        for (i = 2; i >= 0; i--) begin
            op(link_pkg::OP_READ, i == 0, 0);
            chk("id", w[8*i +: 8], q[7:0]);
        end
        op(link_pkg::OP_STOP, 0, 0);
        $display("test id done");
        rsv(`CMD_SLEEP);
        op(link_pkg::OP_STOP, 0, 0);
        chk("sleep", 8'h1, {7'h0, sleep});
        op(link_pkg::OP_START, 0, 0);
        wb({`DEV_TYPE, SEL, 1'b1}, 1'b0, "wake");
        op(link_pkg::OP_STOP, 0, 0);
        chk("awake", 8'h0, {7'h0, sleep});
        // still inside the wake count: refused
        op(link_pkg::OP_START, 0, 0);
        wb({`DEV_TYPE, SEL, 1'b1}, 1'b0, "waking");
        op(link_pkg::OP_STOP, 0, 0);
        rd(1);
        $display("test sleep done");
        give_verdict(0);
    end
endmodule // tb_top
